// *** core/appg_axis.sv ***
// One axis of the pulse profile generator with its AHB-Lite register slave
`timescale 1ns/1ps
`include "appg_defines.svh"
module appg_axis #(
    parameter int SPEED_W = 24,
    parameter int CNT_W = 32
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire appg_pkg::appg_word_t HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire appg_pkg::appg_word_t HWDATA,
    input wire logic HREADY,
    output appg_pkg::appg_word_t HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [3:0] EXT_STOP,
    input wire logic PMODE_JMP,
    output logic PULSE_A,
    output logic PULSE_B,
    output logic BUSY
);
    import appg_pkg::*;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    if (SPEED_W > 31 || CNT_W > 32 || CNT_W < 16) begin : g_bad_param
        $error("appg_axis: SPEED_W or CNT_W out of range");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [`APPG_MODE_W-1:0] mode_q;
    logic [SPEED_W-1:0] init_speed_q;
    logic [SPEED_W-1:0] drive_speed_q;
    logic [SPEED_W-1:0] accel_q;
    logic [SPEED_W-1:0] decel_q;
    logic [CNT_W-1:0] count_q;
    logic [15:0] dec_offset_q;
    logic [`APPG_STOP_CFG_W-1:0] stop_cfg_q;
    appg_word_t cmd_data_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    appg_word_t hrdata_q;
    appg_word_t rd_mux;
    logic ap_take;
    logic wr_en;
    logic [3:0] ext_meta_q;
    logic [3:0] ext_sync_q;
    logic [1:0] jmp_q;
    logic [3:0] ext_act;
    logic ext_dec;
    logic ext_inst;
    appg_state_t state_q;
    appg_state_t state_d;
    logic cont_q;
    logic sep_q;
    logic dstop_q;
    logic [SPEED_W-1:0] cur_speed_q;
    logic [CNT_W-1:0] emitted_q;
    logic [CNT_W-1:0] acc_pulses_q;
    logic [55:0] num_q;
    logic [CNT_W-1:0] rem;
    logic [CNT_W-1:0] rem_off;
    logic [55:0] rem_cost;
    logic need_decel;
    logic cmd_start;
    logic cmd_dstop;
    logic cmd_istop;
    logic cmd_decel;
    logic wr_count;
    logic shrink;
    logic inst_req;
    logic dec_req;
    logic pmode;
    logic pulse_q;
    logic dir_q;

    appg_rate_if #(.RATE_W(SPEED_W)) spd_if ();
    appg_rate_if #(.RATE_W(SPEED_W)) acc_if ();

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    // Zero wait state, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_q;
    assign ap_take = HSEL && HTRANS[1] && HREADY;
    assign wr_en = wr_pend_q;

    // Read mux, unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h00000000;
        case (HADDR[7:0])
            `APPG_OFS_MODE: rd_mux = {{(32-`APPG_MODE_W){1'b0}}, mode_q};
            `APPG_OFS_INIT_SPEED: rd_mux = {{(32-SPEED_W){1'b0}}, init_speed_q};
            `APPG_OFS_DRIVE_SPEED: rd_mux = {{(32-SPEED_W){1'b0}}, drive_speed_q};
            `APPG_OFS_ACCEL: rd_mux = {{(32-SPEED_W){1'b0}}, accel_q};
            `APPG_OFS_COUNT: rd_mux = {{(32-CNT_W){1'b0}}, count_q};
            `APPG_OFS_DEC_OFFSET: rd_mux = {16'h0000, dec_offset_q};
            `APPG_OFS_STOP_CFG: rd_mux = {20'h00000, stop_cfg_q};
            `APPG_OFS_CMD_DATA: rd_mux = cmd_data_q;
            `APPG_OFS_STATUS: rd_mux = {25'h0000000, pmode, state_q, BUSY};
            `APPG_OFS_EMITTED: rd_mux = {{(32-CNT_W){1'b0}}, emitted_q};
            `APPG_OFS_SPEED: rd_mux = {{(32-SPEED_W){1'b0}}, cur_speed_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Address phase capture and read data
    always_ff @(posedge MCLK) begin
        if (RST) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= ap_take && HWRITE;
            if (ap_take) begin
                wr_addr_q <= HADDR[7:0];
            end
            if (ap_take && !HWRITE) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // Command decode in the write data phase
    always_comb begin
        cmd_start = wr_en && wr_addr_q == `APPG_OFS_CMD && HWDATA[7:0] == `APPG_CMD_START;
        cmd_dstop = wr_en && wr_addr_q == `APPG_OFS_CMD && HWDATA[7:0] == `APPG_CMD_DEC_STOP;
        cmd_istop = wr_en && wr_addr_q == `APPG_OFS_CMD && HWDATA[7:0] == `APPG_CMD_INST_STOP;
        cmd_decel = wr_en && wr_addr_q == `APPG_OFS_CMD && HWDATA[7:0] == `APPG_CMD_SET_DECEL;
        wr_count = wr_en && wr_addr_q == `APPG_OFS_COUNT;
    end

    // Parameter registers
    always_ff @(posedge MCLK) begin
        if (RST) begin
            mode_q <= '0;
            init_speed_q <= '0;
            drive_speed_q <= '0;
            accel_q <= '0;
            decel_q <= '0;
            count_q <= '0;
            dec_offset_q <= `APPG_RST_DEC_OFFSET;
            stop_cfg_q <= '0;
            cmd_data_q <= 32'h00000000;
        end else if (wr_en) begin
            case (wr_addr_q)
                `APPG_OFS_MODE: mode_q <= HWDATA[`APPG_MODE_W-1:0];
                `APPG_OFS_INIT_SPEED: init_speed_q <= HWDATA[SPEED_W-1:0];
                `APPG_OFS_DRIVE_SPEED: drive_speed_q <= HWDATA[SPEED_W-1:0];
                `APPG_OFS_ACCEL: accel_q <= HWDATA[SPEED_W-1:0];
                // count may be rewritten while running
                `APPG_OFS_COUNT: count_q <= HWDATA[CNT_W-1:0];
                `APPG_OFS_DEC_OFFSET: dec_offset_q <= HWDATA[15:0];
                `APPG_OFS_STOP_CFG: stop_cfg_q <= HWDATA[`APPG_STOP_CFG_W-1:0];
                `APPG_OFS_CMD_DATA: cmd_data_q <= HWDATA;
                `APPG_OFS_CMD: if (cmd_decel) begin
                    decel_q <= cmd_data_q[SPEED_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // External inputs
    // ----------------------------------------------------------------
    // Two-stage synchronisers for stop inputs and jumper
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ext_meta_q <= 4'h0;
            ext_sync_q <= 4'h0;
            jmp_q <= 2'h0;
        end else begin
            ext_meta_q <= EXT_STOP;
            ext_sync_q <= ext_meta_q;
            jmp_q <= {jmp_q[0], PMODE_JMP};
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_stop_in
        assign ext_act[i] = stop_cfg_q[`APPG_STOP_EN_LSB+i]
            && (ext_sync_q[i] == stop_cfg_q[`APPG_STOP_LVL_LSB+i]);
    end
    assign ext_inst = |(ext_act & stop_cfg_q[`APPG_STOP_MODE_LSB+3:`APPG_STOP_MODE_LSB]);
    assign ext_dec = |(ext_act & ~stop_cfg_q[`APPG_STOP_MODE_LSB+3:`APPG_STOP_MODE_LSB]);

    // signalling mode from jumper or software
    assign pmode = mode_q[`APPG_MODE_SW_SEL] ? mode_q[`APPG_MODE_SW_VAL] : jmp_q[1];

    // ----------------------------------------------------------------
    // Profile control
    // ----------------------------------------------------------------
    assign BUSY = (state_q != ST_IDLE);
    assign inst_req = cmd_istop || ext_inst;
    assign dec_req = cmd_dstop || ext_dec;
    assign shrink = wr_count && !cont_q && (HWDATA[CNT_W-1:0] < count_q);
    assign rem = (count_q > emitted_q) ? count_q - emitted_q : '0;
    assign rem_off = (rem > {{(CNT_W-16){1'b0}}, dec_offset_q})
        ? rem - {{(CNT_W-16){1'b0}}, dec_offset_q} : '0;
    assign rem_cost = 56'(rem_off) * 56'(decel_q);

    always_comb begin
        if (sep_q) begin
            need_decel = (rem_cost <= num_q);
        end else begin
            need_decel = (rem_off <= acc_pulses_q);
        end
    end

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (cmd_start) begin
                // no ramp when drive is not above initial
                state_d = (drive_speed_q > init_speed_q) ? ST_ACCEL : ST_CONST;
            end
            ST_ACCEL: begin
                if (cur_speed_q >= drive_speed_q) begin
                    state_d = ST_CONST;
                end
                if (!cont_q && need_decel) begin
                    state_d = ST_DECEL;
                end
            end
            ST_CONST: if (!cont_q && need_decel && drive_speed_q > init_speed_q) begin
                state_d = ST_DECEL;
            end
            ST_DECEL: if (cur_speed_q <= init_speed_q) begin
                state_d = (!cont_q && !dstop_q && rem != '0) ? ST_OFFSET : ST_IDLE;
            end
            ST_OFFSET: state_d = ST_OFFSET;
            default: state_d = ST_IDLE;
        endcase
        if (state_q != ST_IDLE) begin
            if (dec_req && (state_q == ST_ACCEL || state_q == ST_CONST)) begin
                state_d = (cur_speed_q > init_speed_q) ? ST_DECEL : ST_IDLE;
            end
            if (!cont_q && emitted_q >= count_q) begin
                state_d = ST_IDLE;
            end
            // smaller count ends output at once
            if (shrink) begin
                state_d = ST_IDLE;
            end
            if (inst_req) begin
                state_d = ST_IDLE;
            end
        end
    end

    // State and per-motion latches
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            cont_q <= 1'b0;
            sep_q <= 1'b0;
            dstop_q <= 1'b0;
            dir_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && cmd_start) begin
                cont_q <= mode_q[`APPG_MODE_CONT];
                sep_q <= mode_q[`APPG_MODE_SEP_DECEL];
                dstop_q <= 1'b0;
                dir_q <= mode_q[`APPG_MODE_DIR];
            end else if (BUSY && dec_req) begin
                dstop_q <= 1'b1;
            end
        end
    end

    // Rate generators for pulses and for speed steps
    assign spd_if.rate = cur_speed_q;
    assign spd_if.run = BUSY;
    assign acc_if.rate = (state_q == ST_DECEL && sep_q) ? decel_q : accel_q;
    assign acc_if.run = (state_q == ST_ACCEL) || (state_q == ST_DECEL);

    appg_rate_nco #(.RATE_W(SPEED_W)) u_speed_nco (
        .MCLK(MCLK),
        .RST(RST),
        .RATE(spd_if.gen)
    );

    appg_rate_nco #(.RATE_W(SPEED_W)) u_accel_nco (
        .MCLK(MCLK),
        .RST(RST),
        .RATE(acc_if.gen)
    );

    // Speed, acceleration pulse count and decel cost sum
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cur_speed_q <= '0;
            acc_pulses_q <= '0;
            num_q <= '0;
        end else if (state_q == ST_IDLE) begin
            if (cmd_start) begin
                cur_speed_q <= init_speed_q;
                acc_pulses_q <= '0;
                num_q <= '0;
            end
        end else begin
            if (state_q == ST_ACCEL && acc_if.tick && cur_speed_q < drive_speed_q) begin
                cur_speed_q <= cur_speed_q + 1'b1;
                num_q <= num_q + 56'(cur_speed_q);
            end else if (state_q == ST_DECEL && acc_if.tick && cur_speed_q > init_speed_q) begin
                cur_speed_q <= cur_speed_q - 1'b1;
            end
            if (state_q == ST_ACCEL && spd_if.tick) begin
                acc_pulses_q <= acc_pulses_q + 1'b1;
            end
        end
    end

    // pulse output, suppressed on an instant stop
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pulse_q <= 1'b0;
            emitted_q <= '0;
        end else begin
            pulse_q <= BUSY && spd_if.tick && !inst_req && !shrink;
            if (state_q == ST_IDLE && cmd_start) begin
                emitted_q <= '0;
            end else if (BUSY && spd_if.tick && !inst_req && !shrink) begin
                emitted_q <= emitted_q + 1'b1;
            end
        end
    end

    // Pulse/direction or two-pulse signalling
    assign PULSE_A = pmode ? (pulse_q && !dir_q) : pulse_q;
    assign PULSE_B = pmode ? (pulse_q && dir_q) : dir_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // idle axis gives no pulse
    a_idle_no_pulse: assert property ((state_q == ST_IDLE) |=> !pulse_q)
        else $error("pulse after idle state");
    a_fixed_count_end: assert property (
        (BUSY && !cont_q && emitted_q >= count_q) |=> (state_q == ST_IDLE))
        else $error("fixed-count motion did not end");
    a_offset_reset: assert property (
        disable iff (1'b0) RST |=> (dec_offset_q == 16'h0008))
        else $error("offset not eight after reset");
    a_shrink_stop: assert property ((BUSY && shrink) |=> (state_q == ST_IDLE) && !pulse_q)
        else $error("smaller count did not stop output");
    a_const_speed: assert property (
        (state_q == ST_CONST) ##1 (state_q == ST_CONST) |-> $stable(cur_speed_q))
        else $error("speed moved in constant phase");
    // speed stays at or above initial during ramps
    a_ramp_bounds: assert property (
        (state_q == ST_ACCEL || state_q == ST_DECEL) |-> (cur_speed_q >= init_speed_q))
        else $error("ramp speed below initial");
    a_instant_stop: assert property ((BUSY && cmd_istop) |=> (state_q == ST_IDLE))
        else $error("instant stop command ignored");
    a_ext_stop: assert property ((BUSY && ext_inst) |=> !BUSY ##1 !pulse_q)
        else $error("external instant stop ignored");
    // deceleration point reached in constant phase
    a_decel_point: assert property (
        (state_q == ST_CONST && !cont_q && !sep_q && need_decel && !inst_req && !shrink
         && drive_speed_q > init_speed_q && emitted_q < count_q) |=> (state_q == ST_DECEL))
        else $error("deceleration not started at its point");
    // continuous run holds without a stop
    a_cont_runs: assert property (
        (cont_q && state_q == ST_CONST && !inst_req && !dec_req) |=> (state_q == ST_CONST))
        else $error("continuous motion ended without stop");
endmodule : appg_axis

// *** core/appg_defines.svh ***
// Constants of the axis pulse profile generator: offsets, fields, reset values, timing
// Notes on behaviour
// - Fixed-count mode and continuous mode both supported
// - Signalling mode from jumper pin or register
// - Fixed-count output stops when count reached
// - Larger count written while running extends motion
// - Smaller count written while running in fixed-count mode stops instantly
// - Count change may truncate the deceleration
// - Decelerate when remaining pulses not above accel pulses
// - Offset starts decel early, rest at initial speed
// - Deceleration offset resets to eight pulses
// - Continuous output runs until stop command or input
// - Decelerating stop and instant stop commands
// - Four stop inputs, each enable, level, mode
// - Drive below initial speed gives constant speed
// - Linear ramp up to drive, down to initial
// - Separate decel bit, rate loaded by code 03h
// - Asymmetric profile computes deceleration point internally
`ifndef APPG_DEFINES_SVH
`define APPG_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define APPG_CLK_HZ 32'd125000000

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define APPG_OFS_MODE 8'h00
`define APPG_OFS_INIT_SPEED 8'h04
`define APPG_OFS_DRIVE_SPEED 8'h08
`define APPG_OFS_ACCEL 8'h0c
`define APPG_OFS_COUNT 8'h10
`define APPG_OFS_DEC_OFFSET 8'h14
`define APPG_OFS_STOP_CFG 8'h18
`define APPG_OFS_CMD 8'h1c
`define APPG_OFS_CMD_DATA 8'h20
`define APPG_OFS_STATUS 8'h24
`define APPG_OFS_EMITTED 8'h28
`define APPG_OFS_SPEED 8'h2c

// ----------------------------------------------------------------
// Fields of the accel mode register
// ----------------------------------------------------------------
`define APPG_MODE_CONT 0
`define APPG_MODE_SEP_DECEL 1
`define APPG_MODE_DIR 2
`define APPG_MODE_SW_SEL 3
`define APPG_MODE_SW_VAL 4
`define APPG_MODE_W 5

// Stop configuration: enables, active levels, instant-stop modes
`define APPG_STOP_EN_LSB 0
`define APPG_STOP_LVL_LSB 4
`define APPG_STOP_MODE_LSB 8
`define APPG_STOP_CFG_W 12

// ----------------------------------------------------------------
// Command codes and reset values
// ----------------------------------------------------------------
`define APPG_CMD_SET_DECEL 8'h03
`define APPG_CMD_START 8'h22
`define APPG_CMD_DEC_STOP 8'h26
`define APPG_CMD_INST_STOP 8'h27
`define APPG_RST_DEC_OFFSET 16'h0008

`endif

// *** core/appg_pkg.sv ***
// Types shared by the axis pulse profile generator
package appg_pkg;
    typedef logic [31:0] appg_word_t;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ACCEL = 5'b00010,
        ST_CONST = 5'b00100,
        ST_DECEL = 5'b01000,
        ST_OFFSET = 5'b10000
    } appg_state_t;
endpackage : appg_pkg

// *** core/appg_rate_if.sv ***
// Rate request and tick between the profile logic and a rate accumulator
`timescale 1ns/1ps
interface appg_rate_if #(parameter int RATE_W = 24);
    logic [RATE_W-1:0] rate;
    logic run;
    logic tick;
    modport src (output rate, output run, input tick);
    modport gen (input rate, input run, output tick);
endinterface : appg_rate_if

// *** core/appg_rate_nco.sv ***
// Accumulator that ticks at a rate given in events per second
`timescale 1ns/1ps
`include "appg_defines.svh"
module appg_rate_nco #(
    parameter int RATE_W = 24
) (
    input wire logic MCLK,
    input wire logic RST,
    appg_rate_if.gen RATE
);
    import appg_pkg::*;

    logic [32:0] acc_q;
    logic [32:0] sum;

    if (RATE_W > 31) begin : g_bad_width
        $error("appg_rate_nco: RATE_W above 31 not served");
    end

    // One tick each time the sum passes one second of clocks
    always_comb begin
        sum = acc_q + {{(33-RATE_W){1'b0}}, RATE.rate};
        RATE.tick = RATE.run && (sum >= {1'b0, `APPG_CLK_HZ});
    end

    // Accumulator, cleared while idle so a start has a fixed phase
    always_ff @(posedge MCLK) begin
        if (RST || !RATE.run) begin
            acc_q <= 33'h000000000;
        end else if (RATE.tick) begin
            acc_q <= sum - {1'b0, `APPG_CLK_HZ};
        end else begin
            acc_q <= sum;
        end
    end
endmodule : appg_rate_nco

// *** test/appg_drv_model.sv ***
// Motor driver model that counts the forward steps it is commanded to make
`timescale 1ns/1ps
module appg_drv_model (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PULSE_A,
    input wire logic PULSE_B,
    output int steps
);
    // pulse and direction signalling, forward steps only
    always_ff @(posedge MCLK) begin
        if (RST) begin
            steps <= 0;
        end else if (PULSE_A === 1'b1 && PULSE_B === 1'b0) begin
            steps <= steps + 1;
        end
    end
endmodule : appg_drv_model

// *** test/axis_pulse_profile_generator_tb.sv ***
// Self-checking bench of one pulse generator axis and its driver model
`timescale 1ns/1ps
`include "appg_defines.svh"
module axis_pulse_profile_generator_tb;
    import appg_pkg::*;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [1:0] HTRANS = 2'b00;
    logic [3:0] EXT_STOP = 4'h0;
    logic PMODE_JMP = 1'b0;
    appg_word_t HADDR = '0;
    appg_word_t HWDATA = '0;
    appg_word_t HRDATA;
    logic HREADYOUT, HRESP, PULSE_A, PULSE_B, BUSY;
    int failures = 0;
    int check_count = 0;
    int steps;
    int s0;

    always #4 MCLK = ~MCLK;

    appg_axis DUT (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_STOP(EXT_STOP),
        .PMODE_JMP(PMODE_JMP), .PULSE_A(PULSE_A), .PULSE_B(PULSE_B), .BUSY(BUSY));
    appg_drv_model MOTOR (.MCLK(MCLK), .RST(RST), .PULSE_A(PULSE_A), .PULSE_B(PULSE_B),
        .steps(steps));

    task automatic results();
        $display("Checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input appg_word_t exp, input appg_word_t got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Single AHB-Lite transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] ofs, input appg_word_t wd,
                       output appg_word_t rd);
        int n;
        HSEL <= 1'b1;
        HADDR <= {24'h0, ofs};
        HTRANS <= 2'b10;
        HWRITE <= wr;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        HTRANS <= 2'b00;
        HSEL <= 1'b0;
        HWDATA <= wd;
        do begin
            @(posedge MCLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 100);
        rd = HRDATA;
        if (n >= 100) begin
            failures++;
            results();
        end
    endtask : bus

    task automatic wr(input logic [7:0] ofs, input appg_word_t d);
        appg_word_t x;
        bus(1'b1, ofs, d, x);
    endtask : wr

    task automatic rd_check(input string what, input logic [7:0] ofs, input appg_word_t exp);
        appg_word_t x;
        bus(1'b0, ofs, 32'h0, x);
        check(what, exp, x);
    endtask : rd_check

    // speeds, acceleration, count and mode programmed before the start command
    task automatic go(input appg_word_t mode, input appg_word_t cnt, input appg_word_t drv);
        wr(`APPG_OFS_INIT_SPEED, 32'h00bebc20);
        wr(`APPG_OFS_DRIVE_SPEED, drv);
        wr(`APPG_OFS_ACCEL, 32'h00bebc20);
        wr(`APPG_OFS_COUNT, cnt);
        wr(`APPG_OFS_MODE, mode);
        wr(`APPG_OFS_CMD, {24'h0, `APPG_CMD_START});
        #1;
        check("busy after start", 32'h1, {31'h0, BUSY});
    endtask : go

    task automatic idle_wait();
        int n;
        n = 0;
        while (BUSY !== 1'b0 && n < 3000) begin
            @(posedge MCLK);
            n++;
        end
        if (n >= 3000) begin
            failures++;
            results();
        end
    endtask : idle_wait

    task automatic t_reset();
        rd_check("decel offset", `APPG_OFS_DEC_OFFSET, 32'h00000008);
        rd_check("unmapped", 8'h3c, 32'h00000000);
        rd_check("command reg", `APPG_OFS_CMD, 32'h00000000);
        // Jumper picks the signalling mode unless software selects it
        PMODE_JMP <= 1'b1;
        repeat (3) @(posedge MCLK);
        rd_check("jumper mode", `APPG_OFS_STATUS, 32'h00000042);
        wr(`APPG_OFS_MODE, 32'h00000008);
        rd_check("software mode", `APPG_OFS_STATUS, 32'h00000002);
        PMODE_JMP <= 1'b0;
        $display("test reset values done");
    endtask : t_reset

    task automatic t_fixed();
        s0 = steps;
        go(32'h0, 32'h6, 32'h0);
        // drive below initial speed runs at constant speed
        rd_check("speed", `APPG_OFS_SPEED, 32'h00bebc20);
        idle_wait();
        @(posedge MCLK);
        check("steps", 32'h6, steps - s0);
        rd_check("emitted", `APPG_OFS_EMITTED, 32'h6);
        $display("test fixed count done");
    endtask : t_fixed

    task automatic t_change();
        s0 = steps;
        go(32'h0, 32'd20, 32'h0);
        repeat (40) @(posedge MCLK);
        wr(`APPG_OFS_COUNT, 32'd30);
        idle_wait();
        @(posedge MCLK);
        check("extended steps", 32'd30, steps - s0);
        go(32'h0, 32'd40, 32'h0);
        repeat (60) @(posedge MCLK);
        // Smaller count still above the emitted pulses
        wr(`APPG_OFS_COUNT, 32'd30);
        @(posedge MCLK);
        #1;
        check("busy after shrink", 32'h0, {31'h0, BUSY});
        $display("test count change done");
    endtask : t_change

    task automatic t_cont();
        for (int k = 0; k < 2; k++) begin
            go(32'h1, 32'h0, 32'h00bebc2a);
            repeat (300) @(posedge MCLK);
            check("continuous busy", 32'h1, {31'h0, BUSY});
            wr(`APPG_OFS_CMD, (k == 0) ? 32'h27 : 32'h26);
            if (k == 0) begin
                @(posedge MCLK);
                #1;
                check("instant stop", 32'h0, {31'h0, BUSY});
            end
            idle_wait();
            rd_check("stop speed", `APPG_OFS_SPEED, (k == 0) ? 32'h00bebc2a : 32'h00bebc20);
            s0 = steps;
            repeat (30) @(posedge MCLK);
            check("no steps when idle", s0, steps);
        end
        $display("test continuous stops done");
    endtask : t_cont

    task automatic t_ext();
        int n;
        wr(`APPG_OFS_STOP_CFG, 32'h00000444);
        go(32'h1, 32'h0, 32'h0);
        repeat (50) @(posedge MCLK);
        EXT_STOP <= 4'h4;
        n = 0;
        while (BUSY !== 1'b0 && n < 6) begin
            @(posedge MCLK);
            n++;
        end
        check("external stop", 32'h0, {31'h0, BUSY});
        EXT_STOP <= 4'h0;
        $display("test external stop done");
    endtask : t_ext

    // Ramped fixed-count runs, the second with a separate deceleration
    task automatic t_ramp();
        for (int k = 0; k < 2; k++) begin
            s0 = steps;
            wr(`APPG_OFS_CMD_DATA, 32'h00e4e1c0);
            wr(`APPG_OFS_CMD, {24'h0, `APPG_CMD_SET_DECEL});
            go((k == 0) ? 32'h0 : 32'h2, 32'd60, 32'h00bebc2a);
            repeat (150) @(posedge MCLK);
            rd_check("drive speed reached", `APPG_OFS_SPEED, 32'h00bebc2a);
            idle_wait();
            @(posedge MCLK);
            check("ramped steps", 32'd60, steps - s0);
            rd_check("speed back at initial", `APPG_OFS_SPEED, 32'h00bebc20);
        end
        $display("test ramps done");
    endtask : t_ramp

    initial begin
        repeat (20) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        t_reset();
        t_fixed();
        t_change();
        t_cont();
        t_ext();
        t_ramp();
        results();
    end
endmodule : axis_pulse_profile_generator_tb
